/* reset_event_flags.sv */
/*
 * Reset source and event flag register with AXI4-Lite slave, interrupt
 * enables, output divider setting and loop clock divider.
 * Assumes rst is the power-on reset, sys_rst a one-cycle ordinary system
 * reset strobe, and all strobes are single-cycle pulses in the clk domain.
 * Lock and oscillator status arrive from analog circuits and are synchronised.
 */
`timescale 1ns/10ps
module reset_event_flags #(
   parameter int DIV_W = 6
) (
   // Clock and power-on reset
   input  wire logic                            clk,
   input  wire logic                            rst,
   // Reset sources and events
   input  wire logic                            sys_rst,
   input  wire logic                            low_volt_rst,
   input  wire logic                            illegal_addr_rst,
   input  wire logic                            periodic_tick_timer_end,
   input  wire logic                            pll_lock_in,
   input  wire logic                            osc_running_in,
   input  wire logic                            vco_tick,
   // AXI4-Lite write address
   input  wire logic                            s_axi_awvalid,
   output logic                                 s_axi_awready,
   input  wire logic [flag_reg_pkg::ADDR_W-1:0] s_axi_awaddr,
   // AXI4-Lite write data
   input  wire logic                            s_axi_wvalid,
   output logic                                 s_axi_wready,
   input  wire logic [31:0]                     s_axi_wdata,
   input  wire logic [3:0]                      s_axi_wstrb,
   // AXI4-Lite write response
   output logic                                 s_axi_bvalid,
   input  wire logic                            s_axi_bready,
   output logic [1:0]                           s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic                            s_axi_arvalid,
   output logic                                 s_axi_arready,
   input  wire logic [flag_reg_pkg::ADDR_W-1:0] s_axi_araddr,
   // AXI4-Lite read data
   output logic                                 s_axi_rvalid,
   input  wire logic                            s_axi_rready,
   output logic [31:0]                          s_axi_rdata,
   output logic [1:0]                           s_axi_rresp,
   // Outputs
   output logic                                 irq,
   output logic                                 pll_tick
);

   if (DIV_W < 2 || DIV_W > 8) begin : g_chk
      $error("reset_event_flags: DIV_W must be 2 to 8");
   end

   // Write channel state.
   logic                            aw_full_ff;
   logic                            nxt_aw_full;
   logic [flag_reg_pkg::ADDR_W-1:0] awaddr_ff;
   logic [flag_reg_pkg::ADDR_W-1:0] nxt_awaddr;
   logic                            w_full_ff;
   logic                            nxt_w_full;
   logic [31:0]                     wdata_ff;
   logic [31:0]                     nxt_wdata;
   logic [3:0]                      wstrb_ff;
   logic [3:0]                      nxt_wstrb;
   logic                            bvalid_ff;
   logic                            nxt_bvalid;
   logic [1:0]                      bresp_ff;
   logic [1:0]                      nxt_bresp;
   // Read channel state.
   logic                            rvalid_ff;
   logic                            nxt_rvalid;
   logic [31:0]                     rdata_ff;
   logic [31:0]                     nxt_rdata;
   logic [1:0]                      rresp_ff;
   logic [1:0]                      nxt_rresp;
   // Ready outputs are registered copies of the buffer-empty state.
   logic                            awready_ff;
   logic                            nxt_awready;
   logic                            wready_ff;
   logic                            nxt_wready;
   logic                            arready_ff;
   logic                            nxt_arready;
   // Register state.
   logic [7:0]                      flags_ff;
   logic [7:0]                      nxt_flags;
   logic [7:0]                      ien_ff;
   logic [7:0]                      nxt_ien;
   logic [DIV_W-1:0]                div_ff;
   logic [DIV_W-1:0]                nxt_div;
   logic                            irq_ff;
   logic                            nxt_irq;
   // Synchronisers and edge history.
   logic                            lock_meta_ff;
   logic                            lock_ff;
   logic                            lock_prev_ff;
   logic                            osc_meta_ff;
   logic                            osc_ff;
   logic                            osc_prev_ff;

   logic                            wr_go;
   logic                            rd_go;
   logic [flag_reg_pkg::ADDR_W-1:0] wr_idx;
   logic [flag_reg_pkg::ADDR_W-1:0] rd_idx;
   logic                            wr_hit;
   logic                            rd_hit;
   logic [7:0]                      flag_view;
   logic [7:0]                      set_vec;
   logic [7:0]                      clr_vec;
   logic [7:0]                      rd_byte;

   assign wr_go  = aw_full_ff && w_full_ff && !bvalid_ff;
   assign rd_go  = s_axi_arvalid && !rvalid_ff;
   assign wr_idx = {2'h0, awaddr_ff[flag_reg_pkg::ADDR_W-1:2]};
   assign rd_idx = {2'h0, s_axi_araddr[flag_reg_pkg::ADDR_W-1:2]};
   assign wr_hit = (wr_idx == flag_reg_pkg::FLAG_IDX) || (wr_idx == flag_reg_pkg::CLR_IDX)
                || (wr_idx == flag_reg_pkg::IEN_IDX) || (wr_idx == flag_reg_pkg::DIV_IDX);
   assign rd_hit = (rd_idx == flag_reg_pkg::FLAG_IDX) || (rd_idx == flag_reg_pkg::CLR_IDX)
                || (rd_idx == flag_reg_pkg::IEN_IDX) || (rd_idx == flag_reg_pkg::DIV_IDX);

   // Live status bits are overlaid on the stored flags, never stored.
   always_comb begin
      flag_view = flags_ff;
      flag_view[flag_reg_pkg::LOCK_BIT]   = lock_ff;
      flag_view[flag_reg_pkg::OSCRUN_BIT] = osc_ff;
   end

   // Read mux; the clear register is write-only and reads zero.
   always_comb begin
      rd_byte = 8'h00;
      if (rd_idx == flag_reg_pkg::FLAG_IDX) begin
         rd_byte = flag_view;
      end else if (rd_idx == flag_reg_pkg::IEN_IDX) begin
         rd_byte = ien_ff;
      end else if (rd_idx == flag_reg_pkg::DIV_IDX) begin
         rd_byte = 8'(div_ff);
      end
   end

   // Bus channel next state.
   always_comb begin
      nxt_aw_full = aw_full_ff;
      nxt_awaddr  = awaddr_ff;
      nxt_w_full  = w_full_ff;
      nxt_wdata   = wdata_ff;
      nxt_wstrb   = wstrb_ff;
      nxt_bvalid  = bvalid_ff;
      nxt_bresp   = bresp_ff;
      nxt_rvalid  = rvalid_ff;
      nxt_rdata   = rdata_ff;
      nxt_rresp   = rresp_ff;
      if (s_axi_awvalid && !aw_full_ff) begin
         nxt_aw_full = 1'b1;
         nxt_awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_ff) begin
         nxt_w_full = 1'b1;
         nxt_wdata  = s_axi_wdata;
         nxt_wstrb  = s_axi_wstrb;
      end
      if (wr_go) begin
         nxt_aw_full = 1'b0;
         nxt_w_full  = 1'b0;
         nxt_bvalid  = 1'b1;
         nxt_bresp   = wr_hit ? flag_reg_pkg::RESP_OKAY : flag_reg_pkg::RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
         nxt_bvalid = 1'b0;
      end
      if (rd_go) begin
         nxt_rvalid = 1'b1;
         nxt_rdata  = {24'h000000, rd_byte};
         nxt_rresp  = rd_hit ? flag_reg_pkg::RESP_OKAY : flag_reg_pkg::RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
         nxt_rvalid = 1'b0;
      end
      nxt_awready = !nxt_aw_full;
      nxt_wready  = !nxt_w_full;
      nxt_arready = !nxt_rvalid;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_full_ff <= 1'b0;
         awaddr_ff  <= 8'h00;
         w_full_ff  <= 1'b0;
         wdata_ff   <= 32'h00000000;
         wstrb_ff   <= 4'h0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= 2'h0;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h00000000;
         rresp_ff   <= 2'h0;
         awready_ff <= 1'b1;
         wready_ff  <= 1'b1;
         arready_ff <= 1'b1;
      end else begin
         aw_full_ff <= nxt_aw_full;
         awaddr_ff  <= nxt_awaddr;
         w_full_ff  <= nxt_w_full;
         wdata_ff   <= nxt_wdata;
         wstrb_ff   <= nxt_wstrb;
         bvalid_ff  <= nxt_bvalid;
         bresp_ff   <= nxt_bresp;
         rvalid_ff  <= nxt_rvalid;
         rdata_ff   <= nxt_rdata;
         rresp_ff   <= nxt_rresp;
         awready_ff <= nxt_awready;
         wready_ff  <= nxt_wready;
         arready_ff <= nxt_arready;
      end
   end

   // Hardware set events, one bit each.
   always_comb begin
      set_vec = 8'h00;
      set_vec[flag_reg_pkg::TICK_BIT] = periodic_tick_timer_end;
      set_vec[flag_reg_pkg::LVR_BIT]  = low_volt_rst;
      set_vec[flag_reg_pkg::ILA_BIT]  = illegal_addr_rst;
      set_vec[flag_reg_pkg::LCHG_BIT] = lock_ff ^ lock_prev_ff;
      set_vec[flag_reg_pkg::OCHG_BIT] = osc_ff ^ osc_prev_ff;
   end

   // Only written ones clear, through the flag or the clear register.
   always_comb begin
      clr_vec = 8'h00;
      if (wr_go && wstrb_ff[0]
          && (wr_idx == flag_reg_pkg::FLAG_IDX || wr_idx == flag_reg_pkg::CLR_IDX)) begin
         clr_vec = wdata_ff[7:0] & flag_reg_pkg::W1C_MASK;
      end
   end

   // Register next state.
   always_comb begin
      nxt_flags = flags_ff & ~clr_vec;
      nxt_ien   = ien_ff;
      nxt_div   = div_ff;
      if (wr_go && wstrb_ff[0] && wr_idx == flag_reg_pkg::IEN_IDX) begin
         nxt_ien = wdata_ff[7:0] & flag_reg_pkg::IRQ_MASK;
      end
      if (wr_go && wstrb_ff[0] && wr_idx == flag_reg_pkg::DIV_IDX) begin
         nxt_div = wdata_ff[DIV_W-1:0];
      end
      // A system reset clears event state but keeps reset sources.
      if (sys_rst) begin
         nxt_flags = nxt_flags & ~flag_reg_pkg::EVENT_MASK;
         nxt_ien   = flag_reg_pkg::IEN_RESET;
         nxt_div   = DIV_W'(flag_reg_pkg::DIV_RESET);
      end
      // Sets are applied last so a coinciding clear loses.
      nxt_flags = (nxt_flags | set_vec) & flag_reg_pkg::W1C_MASK;
      // Registered so the output is glitch-free.
      nxt_irq = |(nxt_flags & nxt_ien & flag_reg_pkg::IRQ_MASK);
   end

   // Power-on loads set power-on and low-voltage flags, clear illegal address.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flags_ff <= flag_reg_pkg::FLAG_RESET;
         ien_ff   <= flag_reg_pkg::IEN_RESET;
         div_ff   <= DIV_W'(flag_reg_pkg::DIV_RESET);
         irq_ff   <= 1'b0;
      end else begin
         flags_ff <= nxt_flags;
         ien_ff   <= nxt_ien;
         div_ff   <= nxt_div;
         irq_ff   <= nxt_irq;
      end
   end

   // Two-stage synchronisers; the first stage feeds only the second.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lock_meta_ff <= 1'b0;
         lock_ff      <= 1'b0;
         lock_prev_ff <= 1'b0;
         osc_meta_ff  <= 1'b0;
         osc_ff       <= 1'b0;
         osc_prev_ff  <= 1'b0;
      end else begin
         lock_meta_ff <= pll_lock_in;
         lock_ff      <= lock_meta_ff;
         lock_prev_ff <= lock_ff;
         osc_meta_ff  <= osc_running_in;
         osc_ff       <= osc_meta_ff;
         osc_prev_ff  <= osc_ff;
      end
   end

   pll_tick_divider #(
      .DIV_W (DIV_W)
   ) u_div (
      .clk      (clk),
      .rst      (rst),
      .vco_tick (vco_tick),
      .locked   (lock_ff),
      .post_div (div_ff),
      .pll_tick (pll_tick)
   );

   assign s_axi_awready = awready_ff;
   assign s_axi_wready  = wready_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;
   assign irq           = irq_ff;

endmodule

/* flag_reg_pkg.sv */
/*
 * Constants for the reset source and event flag register block: bus offsets,
 * flag bit positions, masks, reset values and bus response codes.
 * Assumes a byte-addressed AXI4-Lite bus with 32-bit data.
 */
package flag_reg_pkg;

   localparam int ADDR_W = 8;

   // The flag register is printed at an odd offset, so offsets are word indices.
   localparam logic [ADDR_W-1:0] FLAG_IDX = 8'h37;
   localparam logic [ADDR_W-1:0] CLR_IDX  = 8'h38;
   localparam logic [ADDR_W-1:0] IEN_IDX  = 8'h39;
   localparam logic [ADDR_W-1:0] DIV_IDX  = 8'h3A;

   // Flag bit positions.
   localparam int TICK_BIT   = 7;
   localparam int POR_BIT    = 6;
   localparam int LVR_BIT    = 5;
   localparam int LCHG_BIT   = 4;
   localparam int LOCK_BIT   = 3;
   localparam int ILA_BIT    = 2;
   localparam int OCHG_BIT   = 1;
   localparam int OSCRUN_BIT = 0;

   // Bits cleared by writing one.
   localparam logic [7:0] W1C_MASK   = 8'hF6;
   // Bits that can raise the interrupt.
   localparam logic [7:0] IRQ_MASK   = 8'h92;
   // Event flags that an ordinary system reset clears.
   localparam logic [7:0] EVENT_MASK = 8'h92;
   // Power-on state: power-on and low-voltage flags set, illegal-address clear.
   localparam logic [7:0] FLAG_RESET = 8'h60;
   localparam logic [7:0] IEN_RESET  = 8'h00;
   localparam logic [7:0] DIV_RESET  = 8'h00;

   // Divide ratio used while the loop is unlocked, as terminal count.
   localparam logic [7:0] UNLOCK_TERM = 8'h03;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* pll_tick_divider.sv */
/*
 * Derives the loop output clock as a one-cycle enable pulse from the VCO
 * tick enable. Assumes vco_tick is a single-cycle pulse in the clk domain.
 */
`timescale 1ns/10ps
module pll_tick_divider #(
   parameter int DIV_W = 6
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Control
   input  wire logic             vco_tick,
   input  wire logic             locked,
   input  wire logic [DIV_W-1:0] post_div,
   // Output
   output logic                  pll_tick
);

   logic [7:0] cnt_ff;
   logic [7:0] nxt_cnt;
   logic       pll_tick_ff;
   logic       nxt_pll_tick;
   logic [7:0] term;

   if (DIV_W < 2 || DIV_W > 8) begin : g_chk
      $error("pll_tick_divider: DIV_W must be 2 to 8");
   end

   // Unlocked runs at a fixed divide by four to protect the core clock.
   assign term = locked ? 8'(post_div) : flag_reg_pkg::UNLOCK_TERM;

   always_comb begin
      nxt_cnt      = cnt_ff;
      nxt_pll_tick = 1'b0;
      if (vco_tick) begin
         // A count above a freshly lowered terminal wraps at once.
         if (cnt_ff >= term) begin
            nxt_cnt      = 8'h00;
            nxt_pll_tick = 1'b1;
         end else begin
            nxt_cnt = cnt_ff + 8'h01;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_ff      <= 8'h00;
         pll_tick_ff <= 1'b0;
      end else begin
         cnt_ff      <= nxt_cnt;
         pll_tick_ff <= nxt_pll_tick;
      end
   end

   assign pll_tick = pll_tick_ff;

endmodule

/* flag_reg_checker.sv */
/*
 * Port checker for the reset source and event flag block.
 * Assumes it is bound to reset_event_flags and sees only its top ports.
 */
`timescale 1ns/10ps
module flag_reg_checker (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // Stimulus and bus responses seen at the ports
   input wire logic        sys_rst,
   input wire logic        vco_tick,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Outputs
   input wire logic        irq,
   input wire logic        pll_tick
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_aw_take;
      s_axi_awvalid && s_axi_awready;
   endsequence
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence

   property p_write_resp;
      s_wr_take |-> ##2 s_axi_bvalid;
   endproperty
   property p_aw_refuse;
      s_aw_take |=> !s_axi_awready;
   endproperty
   property p_read_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   property p_bvalid_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   property p_rvalid_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_rdata_upper;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
   endproperty
   property p_pll_cause;
      pll_tick |-> $past(vco_tick);
   endproperty
   // Interrupt flags drop only on a software write or an ordinary system reset.
   property p_irq_fall;
      $fell(irq) |-> $rose(s_axi_bvalid) || $past(sys_rst);
   endproperty

   a_write_resp: assert property (p_write_resp) else $error("write response late");
   a_aw_refuse: assert property (p_aw_refuse) else $error("address taken twice");
   a_read_answer: assert property (p_read_answer) else $error("read answer late");
   a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");
   a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data dropped");
   a_rdata_upper: assert property (p_rdata_upper) else $error("upper data not zero");
   a_pll_cause: assert property (p_pll_cause) else $error("loop tick without vco tick");
   a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell with no clear");
endmodule

bind reset_event_flags flag_reg_checker chk_u (
   .clk(clk), .rst(rst), .sys_rst(sys_rst), .vco_tick(vco_tick),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .irq(irq), .pll_tick(pll_tick));

/* testbench.sv */
/*
 * Self-checking bench for the reset source and event flag block.
 * Assumes the flag package and the design files are compiled first.
 */
`timescale 1ns/10ps
module testbench;
   logic clk, rst, sys_rst, lvr, ila, tick, lock, osc, vco;
   logic awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr, irq, pll;
   logic [7:0] awa, ara;
   logic [31:0] wd, rdat;
   logic [1:0] bresp, rresp, r;
   logic [31:0] d;
   int n_fail, checks_done, n_pll, n0;
   typedef struct packed {logic [2:0] ev; logic [7:0] exp;} row_t;
   row_t rows [3] = '{'{3'h4, 8'h80}, '{3'h2, 8'h20}, '{3'h1, 8'h04}};

   reset_event_flags dut_u (.clk(clk), .rst(rst), .sys_rst(sys_rst), .low_volt_rst(lvr),
      .illegal_addr_rst(ila), .periodic_tick_timer_end(tick), .pll_lock_in(lock),
      .osc_running_in(osc), .vco_tick(vco), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
      .s_axi_rready(rr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .irq(irq),
      .pll_tick(pll));

   initial begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) if (pll === 1'b1) n_pll <= n_pll + 1;

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] v);
      logic a, w;
      a = 0;
      w = 0;
      @(posedge clk);
      awv <= 1;
      wv  <= 1;
      awa <= idx << 2;
      wd  <= v;
      br  <= 1;
      while (!(a && w)) begin
         @(posedge clk);
         if (awv && awr) begin
            a = 1;
            awv <= 0;
         end
         if (wv && wr_rdy) begin
            w = 1;
            wv <= 0;
         end
      end
      do @(posedge clk); while (bv !== 1'b1);
      r = bresp;
      br <= 0;
   endtask
   task automatic rd(input logic [7:0] idx);
      @(posedge clk);
      arv <= 1;
      ara <= idx << 2;
      rr  <= 1;
      do @(posedge clk); while (arr !== 1'b1);
      arv <= 0;
      do @(posedge clk); while (rv !== 1'b1);
      d = rdat;
      r = rresp;
      rr <= 0;
   endtask
   task automatic rf(input logic [7:0] idx, input logic [31:0] e);
      rd(idx);
      chk("register", d, e);
   endtask
   task automatic ev(input logic [2:0] e);
      @(posedge clk);
      {tick, lvr, ila} <= e;
      @(posedge clk);
      {tick, lvr, ila} <= 3'h0;
   endtask
   task automatic ci(input logic e);
      @(posedge clk);
      chk("irq", {31'h0, irq}, {31'h0, e});
   endtask
   task automatic vt(input int n, input int e);
      n0 = n_pll;
      repeat (n) begin
         @(posedge clk) vco <= 1;
         @(posedge clk) vco <= 0;
      end
      repeat (3) @(posedge clk);
      chk("loop ticks", n_pll - n0, e);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      #2000000;
      n_fail++;
      stop_test;
   end

   initial begin
      {rst, sys_rst, lvr, ila, tick, lock, osc, vco} = 8'h80;
      {awv, wv, br, arv, rr} = 5'h00;
      {awa, ara, wd, n_pll} = 0;
      repeat (4) @(posedge clk);
      rst <= 0;
      rf(flag_reg_pkg::FLAG_IDX, 32'h60);
      rf(flag_reg_pkg::IEN_IDX, 32'h00);
      wr(flag_reg_pkg::FLAG_IDX, 32'h00);
      rf(flag_reg_pkg::FLAG_IDX, 32'h60);
      wr(flag_reg_pkg::FLAG_IDX, 32'hFF);
      chk("bresp", r, flag_reg_pkg::RESP_OKAY);
      rf(flag_reg_pkg::FLAG_IDX, 32'h00);
      foreach (rows[i]) begin
         ev(rows[i].ev);
         rf(flag_reg_pkg::FLAG_IDX, rows[i].exp);
         wr(flag_reg_pkg::CLR_IDX, rows[i].exp);
         rf(flag_reg_pkg::FLAG_IDX, 32'h00);
      end
      // An ordinary system reset must keep the reset-source flags.
      ev(3'h7);
      @(posedge clk) sys_rst <= 1;
      @(posedge clk) sys_rst <= 0;
      rf(flag_reg_pkg::FLAG_IDX, 32'h24);
      wr(flag_reg_pkg::FLAG_IDX, 32'h24);
      vt(8, 2);
      lock <= 1;
      repeat (5) @(posedge clk);
      rf(flag_reg_pkg::FLAG_IDX, 32'h18);
      // Writing one to the live lock bit must not disturb it.
      wr(flag_reg_pkg::FLAG_IDX, 32'h18);
      rf(flag_reg_pkg::FLAG_IDX, 32'h08);
      wr(flag_reg_pkg::DIV_IDX, 32'h01);
      vt(8, 4);
      wr(flag_reg_pkg::DIV_IDX, 32'h03);
      vt(8, 2);
      wr(flag_reg_pkg::IEN_IDX, 32'h90);
      ci(0);
      ev(3'h4);
      ci(1);
      wr(flag_reg_pkg::IEN_IDX, 32'h10);
      ci(0);
      wr(flag_reg_pkg::IEN_IDX, 32'h90);
      ci(1);
      wr(flag_reg_pkg::CLR_IDX, 32'h80);
      ci(0);
      // The tick lands on the very edge at which the clear is applied.
      fork
         wr(flag_reg_pkg::CLR_IDX, 32'h80);
         begin
            @(posedge clk);
            @(posedge clk) tick <= 1;
            @(posedge clk) tick <= 0;
         end
      join
      rf(flag_reg_pkg::FLAG_IDX, 32'h88);
      wr(flag_reg_pkg::CLR_IDX, 32'h80);
      lock <= 0;
      repeat (5) @(posedge clk);
      ci(1);
      rf(flag_reg_pkg::FLAG_IDX, 32'h10);
      wr(flag_reg_pkg::CLR_IDX, 32'h10);
      ci(0);
      rd(8'h10);
      chk("unmapped read data", d, 32'h0);
      chk("unmapped read resp", r, flag_reg_pkg::RESP_SLVERR);
      wr(8'h10, 32'hFF);
      chk("unmapped write", r, flag_reg_pkg::RESP_SLVERR);
      // A second power-on reset must clear the illegal-address flag.
      ev(3'h1);
      @(posedge clk) rst <= 1;
      repeat (2) @(posedge clk);
      rst <= 0;
      rf(flag_reg_pkg::FLAG_IDX, 32'h60);
      // With the power-on and low-voltage flags set, a system reset must keep them.
      @(posedge clk) sys_rst <= 1;
      @(posedge clk) sys_rst <= 0;
      rf(flag_reg_pkg::FLAG_IDX, 32'h60);
      stop_test;
   end
endmodule
